// ===== core/pcs_cfg.svh
/*
  Constants of the program counter, return stack and indirect addressing block.
  Assumes one core clock, APB register access, and decode logic on the same clock.
*/
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define PCS_PC_W      13
`define PCS_LATCH_W   5
`define PCS_TGT_W     11
`define PCS_SP_W      3
`define PCS_DEPTH     8
`define PCS_DADDR_W   9
`define PCS_BYTE_W    8
`define PCS_ADDR_W    12
`define PCS_DATA_W    32

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PCS_OFF_PORT   12'h000
`define PCS_OFF_LOW    12'h008
`define PCS_OFF_STAT   12'h00c
`define PCS_OFF_PTR    12'h010
`define PCS_OFF_LATCH  12'h028

// ----------------------------------------
// fields and values
// ----------------------------------------
`define PCS_PAGE_BIT  3
`define PCS_PAGE_TOP  4
`define PCS_BANK_BIT  7
`define PCS_PC_RST    13'h0000
`define PCS_PC_INC    13'h0001
`define PCS_IRQ_VEC   13'h0004
`define PCS_BYTE_ZERO 8'h00
`define PCS_WORD_ZERO 32'h0000_0000
`define PCS_PAD_ZERO  24'h00_0000
`define PCS_LATCH_RST 5'h00
`define PCS_SP_RST    3'h0
`define PCS_SP_ONE    3'h1

`endif

// ===== core/pcs_core.sv
/*
  Program counter, return stack, page select and indirect data path, with APB access
  to the counter low byte, high latch, pointer, bank bit and indirect port.
  Assumes decode issues at most one command a cycle on pclk and that data memory
  answers a read combinationally while its read strobe is high.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "pcs_cfg.svh"

module pcs_core
    import pcs_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`PCS_ADDR_W-1:0]   paddr,
    input  wire logic [`PCS_DATA_W-1:0]   pwdata,
    output logic      [`PCS_DATA_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire pcs_cmd_type              cmd,
    input  wire logic [`PCS_BYTE_W-1:0]   dmem_rdata,
    output pcs_dmem_type                  dmem_req,
    output logic      [`PCS_PC_W-1:0]     pc_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    pcs_state_type                st_reg;
    pcs_state_type                st_next;
    logic [`PCS_PC_W-1:0]         pc_reg;
    logic [`PCS_PC_W-1:0]         pc_next;
    logic [`PCS_LATCH_W-1:0]      latch_reg;
    logic [`PCS_BYTE_W-1:0]       ptr_reg;
    logic                         bank_reg;
    logic [`PCS_DATA_W-1:0]       prdata_reg;
    logic [`PCS_DATA_W-1:0]       prdata_next;
    logic                         pready_reg;
    logic                         pready_next;
    logic                         pslverr_reg;
    logic                         pslverr_next;
    pcs_dmem_type                 dmem_reg;
    pcs_dmem_type                 dmem_next;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire access    = psel & penable;
    wire sel_port  = (paddr == `PCS_OFF_PORT);
    wire sel_low   = (paddr == `PCS_OFF_LOW);
    wire sel_stat  = (paddr == `PCS_OFF_STAT);
    wire sel_ptr   = (paddr == `PCS_OFF_PTR);
    wire sel_latch = (paddr == `PCS_OFF_LATCH);
    wire mapped    = sel_port | sel_low | sel_stat | sel_ptr | sel_latch;

    // a write lands only at the edge where the master sees pready high
    wire commit    = access & pready_reg;
    wire wr_commit = commit & pwrite;

    wire low_wr    = wr_commit & sel_low;
    wire latch_wr  = wr_commit & sel_latch;
    wire ptr_wr    = wr_commit & sel_ptr;
    wire stat_wr   = wr_commit & sel_stat;

    // ----------------------------------------
    // indirect path
    // ----------------------------------------
    wire                     ind_self = (ptr_reg == `PCS_BYTE_ZERO);
    wire [`PCS_DADDR_W-1:0]  ind_addr = {bank_reg, ptr_reg};
    wire ind_rd_start = (st_reg == PCS_ST_IDLE) & access & ~pwrite
                        & sel_port & ~ind_self;
    wire ind_wr       = wr_commit & sel_port & ~ind_self;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // the upper counter bits have no read path at all
    wire [`PCS_BYTE_W-1:0] rd_byte =
        sel_low   ? pc_reg[`PCS_BYTE_W-1:0] :
        sel_ptr   ? ptr_reg :
        sel_latch ? {3'h0, latch_reg} :
        sel_stat  ? {bank_reg, 7'h00} :
        `PCS_BYTE_ZERO;
    wire [`PCS_DATA_W-1:0] rd_word = {`PCS_PAD_ZERO, rd_byte};

    // ----------------------------------------
    // apb handshake
    // ----------------------------------------
    always_comb begin
        st_next      = st_reg;
        pready_next  = 1'b0;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        case (st_reg)
            PCS_ST_IDLE: begin
                if (ind_rd_start) begin
                    st_next = PCS_ST_MEM;
                end else if (access) begin
                    st_next      = PCS_ST_DONE;
                    pready_next  = 1'b1;
                    prdata_next  = pwrite ? `PCS_WORD_ZERO : rd_word;
                    pslverr_next = ~mapped;
                end
            end
            PCS_ST_MEM: begin
                st_next     = PCS_ST_DONE;
                pready_next = 1'b1;
                prdata_next = {`PCS_PAD_ZERO, dmem_rdata};
            end
            PCS_ST_DONE: begin
                st_next = PCS_ST_IDLE;
            end
            default: begin
                st_next = PCS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg      <= PCS_ST_IDLE;
            pready_reg  <= 1'b0;
            prdata_reg  <= `PCS_WORD_ZERO;
            pslverr_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ----------------------------------------
    // data memory request
    // ----------------------------------------
    // strobes last one cycle; a port-to-itself access never reaches memory
    always_comb begin
        dmem_next       = dmem_reg;
        dmem_next.rd    = ind_rd_start;
        dmem_next.wr    = ind_wr;
        if (ind_rd_start || ind_wr) begin
            dmem_next.addr  = ind_addr;
            dmem_next.wdata = pwdata[`PCS_BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmem_reg <= '0;
        end else begin
            dmem_reg <= dmem_next;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // only software writes the latch; calls, returns and interrupts leave it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= `PCS_LATCH_RST;
        end else if (latch_wr) begin
            latch_reg <= pwdata[`PCS_LATCH_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg  <= `PCS_BYTE_ZERO;
            bank_reg <= 1'b0;
        end else begin
            if (ptr_wr) begin
                ptr_reg <= pwdata[`PCS_BYTE_W-1:0];
            end
            if (stat_wr) begin
                bank_reg <= pwdata[`PCS_BANK_BIT];
            end
        end
    end

    // ----------------------------------------
    // stack control
    // ----------------------------------------
    wire cmd_ok  = cmd.valid & ~low_wr;
    wire is_call = cmd_ok & (cmd.op == PCS_OP_CALL);
    wire is_irq  = cmd_ok & (cmd.op == PCS_OP_IRQ);
    wire is_goto = cmd_ok & (cmd.op == PCS_OP_GOTO);
    wire is_step = cmd_ok & (cmd.op == PCS_OP_STEP);
    wire is_ret  = cmd_ok & ((cmd.op == PCS_OP_RET) |
                   (cmd.op == PCS_OP_RETLIT) | (cmd.op == PCS_OP_RETINT));
    wire push    = is_call | is_irq;
    wire pop     = is_ret;

    wire [`PCS_PC_W-1:0] pc_inc   = pc_reg + `PCS_PC_INC;
    wire [`PCS_PC_W-1:0] push_val = is_irq ? pc_reg : pc_inc;
    wire [`PCS_PC_W-1:0] stk_top;

    // page bits above the 11-bit target come from the latch
    wire [`PCS_PC_W-1:0] abs_tgt  = {latch_reg[`PCS_PAGE_TOP],
                                     latch_reg[`PCS_PAGE_BIT],
                                     cmd.target};
    wire [`PCS_PC_W-1:0] low_tgt  = {latch_reg,
                                     pwdata[`PCS_BYTE_W-1:0]};

    pcs_stack u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (push),
        .pop     (pop),
        .din     (push_val),
        .top     (stk_top)
    );

    // ----------------------------------------
    // program counter
    // ----------------------------------------
    // a low byte write beats any decode command in the same cycle
    always_comb begin
        pc_next = pc_reg;
        if (low_wr) begin
            pc_next = low_tgt;
        end else if (is_step) begin
            pc_next = pc_inc;
        end else if (is_goto || is_call) begin
            pc_next = abs_tgt;
        end else if (is_irq) begin
            pc_next = `PCS_IRQ_VEC;
        end else if (is_ret) begin
            pc_next = stk_top;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= `PCS_PC_RST;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign dmem_req = dmem_reg;
    assign pc_out   = pc_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_call;
        is_call;
    endsequence

    sequence s_quiet_ret;
        is_ret && !is_call && !is_irq;
    endsequence

    a_pc_abs_target: assert property (
        (is_goto || is_call) |=> pc_out == {$past(latch_reg[`PCS_PAGE_TOP]),
            $past(latch_reg[`PCS_PAGE_BIT]), $past(cmd.target)})
        else $error("absolute branch target wrong");

    a_call_ret_pair: assert property (
        s_call ##1 s_quiet_ret |=> pc_out == $past(pc_reg, 2) + `PCS_PC_INC)
        else $error("return did not restore call address");

    a_latch_kept_stack: assert property (
        (push || pop) && !latch_wr |=> $stable(latch_reg))
        else $error("stack traffic changed high latch");

    a_low_jump_full: assert property (
        low_wr |=> pc_out == {$past(latch_reg), $past(pwdata[`PCS_BYTE_W-1:0])})
        else $error("low byte write did not load full counter");

    a_port_self_read: assert property (
        access && !pwrite && sel_port && ind_self && st_reg == PCS_ST_IDLE
        |=> pready && prdata == `PCS_WORD_ZERO && !dmem_req.rd)
        else $error("self indirect read not zero");

    a_port_self_write: assert property (
        wr_commit && sel_port && ind_self |=> !dmem_req.wr)
        else $error("self indirect write reached memory");

    a_ind_addr_form: assert property (
        ind_rd_start |=> dmem_req.rd && dmem_req.addr == $past(ind_addr)
        ##1 pready && prdata[7:0] == $past(dmem_rdata))
        else $error("indirect read path wrong");

    a_irq_vector: assert property (
        is_irq |=> pc_out == `PCS_IRQ_VEC ##0 u_stack.top == $past(pc_reg))
        else $error("interrupt branch wrong");

    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    // upper counter bits have no read path, so reads show only the low byte
    a_step_incr: assert property (
        is_step |=> pc_out == $past(pc_reg) + `PCS_PC_INC)
        else $error("step did not advance counter");

    a_low_read_path: assert property (
        access && !pwrite && sel_low && st_reg == PCS_ST_IDLE
        |=> pready && prdata == {`PCS_PAD_ZERO, $past(pc_reg[`PCS_BYTE_W-1:0])})
        else $error("low byte read path wrong");

    a_latch_sw_only: assert property (
        !latch_wr |=> $stable(latch_reg))
        else $error("high latch changed without a write");

    a_call_push_val: assert property (
        is_call |=> stk_top == $past(pc_reg) + `PCS_PC_INC)
        else $error("call pushed wrong return address");

    a_ret_pops_top: assert property (
        is_ret |=> pc_out == $past(stk_top))
        else $error("return did not load stack top");

    a_goto_no_push: assert property (
        is_goto |=> $stable(u_stack.sp_reg))
        else $error("goto moved the stack pointer");

    sequence s_port_wr;
        ind_wr;
    endsequence

    a_port_write_path: assert property (
        s_port_wr |=> dmem_req.wr && dmem_req.addr == $past(ind_addr)
        && dmem_req.wdata == $past(pwdata[`PCS_BYTE_W-1:0]))
        else $error("indirect write path wrong");

    a_mem_rd_pulse: assert property (
        dmem_req.rd |=> !dmem_req.rd)
        else $error("memory read strobe held too long");

endmodule // pcs_core

// ===== core/pcs_pkg.sv
/*
  Types shared by the block: commands from decode, data-memory request, APB states.
  Assumes the constants header is on the include path.
*/
`include "pcs_cfg.svh"

package pcs_pkg;

    typedef enum logic [6:0] {
        PCS_OP_STEP   = 7'h01,
        PCS_OP_GOTO   = 7'h02,
        PCS_OP_CALL   = 7'h04,
        PCS_OP_RET    = 7'h08,
        PCS_OP_RETLIT = 7'h10,
        PCS_OP_RETINT = 7'h20,
        PCS_OP_IRQ    = 7'h40
    } pcs_op_type;

    typedef struct packed {
        logic                     valid;
        pcs_op_type               op;
        logic [`PCS_TGT_W-1:0]    target;
    } pcs_cmd_type;

    typedef struct packed {
        logic                     rd;
        logic                     wr;
        logic [`PCS_DADDR_W-1:0]  addr;
        logic [`PCS_BYTE_W-1:0]   wdata;
    } pcs_dmem_type;

    typedef enum logic [2:0] {
        PCS_ST_IDLE = 3'b001,
        PCS_ST_MEM  = 3'b010,
        PCS_ST_DONE = 3'b100
    } pcs_state_type;

endpackage

// ===== core/pcs_stack.sv
/*
  Eight-entry circular return-address stack in flip-flops.
  Assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/100ps
`include "pcs_cfg.svh"

module pcs_stack
    import pcs_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   push,
    input  wire logic                   pop,
    input  wire logic [`PCS_PC_W-1:0]   din,
    output logic      [`PCS_PC_W-1:0]   top
);

    // ----------------------------------------
    // pointer
    // ----------------------------------------
    // no overflow or underflow flag: the count simply wraps
    logic [`PCS_SP_W-1:0] sp_reg;
    logic [`PCS_SP_W-1:0] sp_next;
    logic [`PCS_SP_W-1:0] sp_top;
    logic [`PCS_PC_W-1:0] mem_reg [`PCS_DEPTH];

    assign sp_next = push ? sp_reg + `PCS_SP_ONE :
                     pop  ? sp_reg - `PCS_SP_ONE : sp_reg;
    assign sp_top  = sp_reg - `PCS_SP_ONE;
    assign top     = mem_reg[sp_top];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= `PCS_SP_RST;
        end else begin
            sp_reg <= sp_next;
        end
    end

    // ----------------------------------------
    // entries
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PCS_DEPTH; gi++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_reg[gi] <= `PCS_PC_RST;
                end else if (push && sp_reg == `PCS_SP_W'(gi)) begin
                    mem_reg[gi] <= din;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_sp_wrap_push: assert property (@(posedge pclk) disable iff (!presetn)
        push && sp_reg == 3'h7 |=> sp_reg == 3'h0)
        else $error("stack pointer did not wrap on push");
    a_push_then_pop: assert property (@(posedge pclk) disable iff (!presetn)
        push ##1 pop |-> top == $past(din))
        else $error("pop after push gave wrong entry");

endmodule // pcs_stack

// ===== test/pcs_dmem_model.sv
/*
  Data memory seen by the indirect path: 512 bytes, read answered at once.
  Assumes the core strobes rd or wr for one cycle and keeps addr stable then.
*/
`timescale 1ns/100ps
`include "pcs_cfg.svh"

module pcs_dmem_model
    import pcs_pkg::*;
(
    input  wire logic         pclk,
    input  wire pcs_dmem_type req,
    output logic [7:0]        rdata,
    output logic [8:0]        wr_addr,
    output logic [7:0]        wr_data,
    output int                wr_count
);
    logic [7:0] mem [512];
    logic [7:0] last;

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
        last = 8'h00;
        wr_count = 0;
        wr_addr = 9'h000;
        wr_data = 8'h00;
    end

    // outside a read the bus shows the inverse of the last byte, never a stale match
    assign rdata = req.rd ? mem[req.addr] : ~last;

    always @(posedge pclk) begin
        if (req.rd) begin
            last <= mem[req.addr];
        end
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
            wr_addr <= req.addr;
            wr_data <= req.wdata;
            wr_count <= wr_count + 1;
        end
    end
endmodule // pcs_dmem_model

// ===== test/tb_pcs_core.sv
/*
  Self-checking bench of the core: apb master, decode commands, data memory model.
  Assumes the hand-over latencies: apb answer after a wait state, pc next cycle.
*/
`timescale 1ns/100ps
`include "pcs_cfg.svh"

module tb_pcs_core
    import pcs_pkg::*;
;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    pcs_cmd_type  cmd = '0;
    logic [7:0]   dmem_rdata;
    pcs_dmem_type dmem_req;
    logic [12:0]  pc_out;
    logic [8:0]   wr_addr;
    logic [7:0]   wr_data;
    int           wr_count;
    int           n_errors = 0;
    int           tests_run = 0;
    int           cycles = 0;

    always #10 pclk = ~pclk;

    pcs_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd(cmd), .dmem_rdata(dmem_rdata), .dmem_req(dmem_req), .pc_out(pc_out));

    pcs_dmem_model u_mem (.pclk(pclk), .req(dmem_req), .rdata(dmem_rdata), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_count(wr_count));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // bounded so a dead design cannot hang the run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no limit of its own: only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask

    task automatic op(input pcs_op_type o, input logic [10:0] t);
        @(posedge pclk);
        cmd <= '{1'b1, o, t};
        @(posedge pclk);
        cmd.valid <= 1'b0;
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        chk("pc reset", 32'h0, pc_out);
        rd_chk("low byte reset", `PCS_OFF_LOW, 32'h0);
        rd_chk("latch reset", `PCS_OFF_LATCH, 32'h0);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, r);
    endtask

    task automatic t_low();
        wr(`PCS_OFF_LATCH, 32'h15);
        wr(`PCS_OFF_LOW, 32'h3c);
        #1;
        chk("computed jump", 32'h153c, pc_out);
        rd_chk("low byte back", `PCS_OFF_LOW, 32'h3c);
        rd_chk("latch back", `PCS_OFF_LATCH, 32'h15);
    endtask

    task automatic t_page();
        wr(`PCS_OFF_LATCH, 32'h08);
        op(PCS_OP_GOTO, 11'h123);
        chk("goto page1", 32'h0923, pc_out);
        wr(`PCS_OFF_LATCH, 32'h10);
        op(PCS_OP_GOTO, 11'h7ff);
        chk("goto top", 32'h17ff, pc_out);
        op(PCS_OP_STEP, 11'h000);
        chk("step", 32'h1800, pc_out);
    endtask

    // a return right behind its call, with no idle cycle between them
    task automatic t_pair();
        logic [12:0] p;
        p = pc_out;
        @(posedge pclk);
        cmd <= '{1'b1, PCS_OP_CALL, 11'h055};
        @(posedge pclk);
        cmd <= '{1'b1, PCS_OP_RET, 11'h000};
        #1;
        chk("pair call", 32'h0855, pc_out);
        @(posedge pclk);
        cmd.valid <= 1'b0;
        #1;
        chk("pair return", {19'h0, p + 13'h1}, pc_out);
    endtask

    task automatic t_stack();
        logic [12:0] stk [8];
        logic [2:0]  sp;
        logic [12:0] p;
        pcs_op_type  rets [3];
        rets = '{PCS_OP_RET, PCS_OP_RETLIT, PCS_OP_RETINT};
        sp = 3'h0;
        wr(`PCS_OFF_LATCH, 32'h08);
        op(PCS_OP_GOTO, 11'h000);
        p = 13'h0800;
        // ten pushes into eight slots: the last two overwrite the first two
        for (int i = 0; i < 10; i++) begin
            if (i < 9) begin
                stk[sp] = p + 13'h1;
                p = {2'b01, 11'h100 + i[10:0]};
                op(PCS_OP_CALL, 11'h100 + i[10:0]);
            end else begin
                stk[sp] = p;
                p = `PCS_IRQ_VEC;
                op(PCS_OP_IRQ, 11'h000);
            end
            sp++;
            chk("push pc", {19'h0, p}, pc_out);
        end
        for (int i = 0; i < 10; i++) begin
            sp--;
            p = stk[sp];
            op(rets[i % 3], 11'h000);
            chk("pop pc", {19'h0, p}, pc_out);
        end
        rd_chk("latch kept", `PCS_OFF_LATCH, 32'h08);
        rd_chk("low byte of pop", `PCS_OFF_LOW, {24'h0, p[7:0]});
    endtask

    task automatic t_indirect();
        int c;
        wr(`PCS_OFF_PTR, 32'h25);
        wr(`PCS_OFF_STAT, 32'h80);
        wr(`PCS_OFF_PORT, 32'h5a);
        repeat (2) @(posedge pclk);
        chk("ind wr addr", 32'h125, wr_addr);
        chk("ind wr data", 32'h5a, wr_data);
        rd_chk("ind rd back", `PCS_OFF_PORT, 32'h5a);
        wr(`PCS_OFF_STAT, 32'h00);
        wr(`PCS_OFF_PTR, 32'h30);
        rd_chk("ind rd bank0", `PCS_OFF_PORT, 32'h95);
        wr(`PCS_OFF_PTR, 32'h00);
        rd_chk("ind self rd", `PCS_OFF_PORT, 32'h0);
        c = wr_count;
        wr(`PCS_OFF_PORT, 32'h77);
        repeat (3) @(posedge pclk);
        chk("ind self wr", c, wr_count);
        rd_chk("pointer kept", `PCS_OFF_PTR, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_low();
        t_page();
        t_stack();
        t_pair();
        t_indirect();
        test_done();
    end
endmodule // tb_pcs_core
